// ### lsr_bank.sv
// Serial register bank with config FIFO, output gating, faults and check remainder
`timescale 1ns/1ns

// ==========================================================
// Configuration word FIFO
module lsr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule

// ==========================================================
// Register bank top
module lsr_bank #(
  parameter int FIFO_DEPTH = lsr_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic shift_clock,
  input wire logic storage_latch_clock,
  input wire logic serial_in,
  input wire logic output_enable_a_n,
  input wire logic output_enable_b_n,
  input wire logic device_enable_n,
  input wire logic clear_n,
  input wire logic power_good,
  input wire logic overtemp_detect,
  input wire logic [7:0] open_detect,
  input wire logic [7:0] short_detect,
  input wire logic apply_ready,
  output logic [15:0] channel_on,
  output logic [7:0] sense_enable,
  output logic serial_out,
  output logic error_out,
  output logic error_oe,
  output logic latch_ready
);
  // ==========================================================
  // Check remainder
  function automatic logic [5:0] crc_calc(input logic [23:0] d);
    logic [5:0] r;
    logic fb;
    r = '0;
    for (int i = lsr_pkg::CFG_W - 1; i >= 0; i--) begin
      fb = r[lsr_pkg::CRC_W-1] ^ d[i];
      r = {r[lsr_pkg::CRC_W-2:0], 1'b0} ^ (fb ? lsr_pkg::CRC_POLY[5:0] : 6'h00);
    end
    return r;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [lsr_pkg::SYNC_W-1:0] sync1_reg;
  logic [lsr_pkg::SYNC_W-1:0] sync2_reg;
  wire [lsr_pkg::SYNC_W-1:0] pins = {shift_clock, storage_latch_clock, serial_in,
    output_enable_a_n, output_enable_b_n, device_enable_n, clear_n, power_good,
    overtemp_detect, open_detect, short_detect};
  always_ff @(posedge ref_clk) begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
  end
  wire sck_s = sync2_reg[24];
  wire lck_s = sync2_reg[23];
  wire sdi_s = sync2_reg[22];
  wire oea_n_s = sync2_reg[21];
  wire oeb_n_s = sync2_reg[20];
  wire en_n_s = sync2_reg[19];
  wire clr_n_s = sync2_reg[18];
  wire pgood_s = sync2_reg[17];
  wire ot_s = sync2_reg[16];
  wire [7:0] open_s = sync2_reg[15:8];
  wire [7:0] short_s = sync2_reg[7:0];

  // Defaults forced by power loss, standby or clear
  wire hold_default = srst | ~pgood_s | en_n_s | ~clr_n_s;

  logic sck_d_reg;
  logic lck_d_reg;
  always_ff @(posedge ref_clk) begin
    sck_d_reg <= sck_s;
    lck_d_reg <= lck_s;
  end
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;
  wire lck_rise = lck_s & ~lck_d_reg;

  // ==========================================================
  // Shift chains
  logic [23:0] shift_in_reg;
  logic [23:0] shift_out_reg;
  logic [17:0] flags_reg;
  logic [23:0] cfg_reg;
  wire [5:0] crc_now = crc_calc(cfg_reg);
  wire [23:0] fault_word = {flags_reg, crc_now};
  always_ff @(posedge ref_clk) begin
    if (hold_default) begin
      shift_in_reg <= lsr_pkg::CFG_RESET;
      shift_out_reg <= lsr_pkg::CFG_RESET;
    end else begin
      if (sck_rise) begin
        shift_in_reg <= {shift_in_reg[22:0], sdi_s};
      end
      if (lck_rise) begin
        shift_out_reg <= fault_word;
      end else if (sck_fall) begin
        shift_out_reg <= {shift_out_reg[22:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Storage through FIFO
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [23:0] fifo_out_data;
  lsr_fifo #(.WIDTH(lsr_pkg::CFG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(hold_default),
    .in_valid(lck_rise),
    .in_ready(fifo_in_ready),
    .in_data(shift_in_reg),
    .out_valid(fifo_out_valid),
    .out_ready(apply_ready),
    .out_data(fifo_out_data)
  );
  always_ff @(posedge ref_clk) begin
    if (hold_default) begin
      cfg_reg <= lsr_pkg::CFG_RESET;
    end else if (fifo_out_valid & apply_ready) begin
      cfg_reg <= fifo_out_data;
    end
  end

  // ==========================================================
  // Channel decode
  wire [7:0] pair_sel = cfg_reg[lsr_pkg::SEL_LSB +: lsr_pkg::NUM_PAIRS];
  wire [15:0] sw_bits = cfg_reg[lsr_pkg::SW_LSB +: lsr_pkg::NUM_CH];
  logic [7:0] odd_bits;
  logic [7:0] even_bits;
  always_comb begin
    for (int k = 0; k < lsr_pkg::NUM_PAIRS; k++) begin
      odd_bits[k] = sw_bits[2*k+1];
      even_bits[k] = sw_bits[2*k];
    end
  end
  wire [7:0] pair_conflict = pair_sel & odd_bits;
  wire [7:0] diag_mode = pair_sel & ~odd_bits;
  wire outputs_live = ~oea_n_s & ~oeb_n_s & ~ot_s;
  logic [15:0] drive_next;
  always_comb begin
    for (int k = 0; k < lsr_pkg::NUM_PAIRS; k++) begin
      drive_next[2*k] = even_bits[k] & outputs_live;
      drive_next[2*k+1] = odd_bits[k] & ~diag_mode[k] & outputs_live;
    end
  end
  wire [7:0] sense_next = diag_mode & even_bits & {8{outputs_live}};

  // ==========================================================
  // Fault flags
  logic [17:0] flag_set;
  always_comb begin
    for (int k = 0; k < lsr_pkg::NUM_PAIRS; k++) begin
      flag_set[2*k+3] = open_s[k] & sense_next[k];
      flag_set[2*k+2] = short_s[k] & sense_next[k];
    end
    flag_set[lsr_pkg::FLT_OT_BIT - lsr_pkg::CRC_W] = ot_s;
    flag_set[lsr_pkg::FLT_CMD_BIT - lsr_pkg::CRC_W] = |pair_conflict;
  end
  // Set wins over the read clear
  wire [17:0] flags_next = flag_set | (flags_reg & {18{~lck_rise}});
  always_ff @(posedge ref_clk) begin
    if (hold_default) begin
      flags_reg <= lsr_pkg::FLAG_RESET;
      channel_on <= '0;
      sense_enable <= '0;
      error_oe <= 1'b0;
      latch_ready <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      channel_on <= drive_next;
      sense_enable <= sense_next;
      error_oe <= |flags_next;
      latch_ready <= fifo_in_ready;
    end
  end
  always_ff @(posedge ref_clk) begin
    error_out <= 1'b0;
  end
  assign serial_out = shift_out_reg[lsr_pkg::CFG_W-1];

  // ==========================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_gate_off: assert property ((oea_n_s | oeb_n_s) |=> channel_on == 16'h0000)
    else $error("channel on while disabled");
  chk_standby_hold: assert property (en_n_s |=> cfg_reg == 24'h000000 && flags_reg == 18'h0)
    else $error("standby did not hold defaults");
  chk_power_down: assert property (!pgood_s |=> channel_on == 16'h0000 && !error_oe)
    else $error("outputs live without power");
  chk_diag_odd: assert property (diag_mode[0] && outputs_live && !hold_default
    |=> !channel_on[1] && sense_enable[0] == $past(cfg_reg[0]))
    else $error("diag channel driven");
  chk_cmd_error: assert property (!hold_default && pair_conflict != 8'h0 |=> flags_reg[0] && error_oe)
    else $error("command error missed");
  chk_read_load: assert property (!hold_default && lck_rise |=> shift_out_reg == $past(fault_word))
    else $error("fault word not loaded");
  chk_shift_out: assert property (!hold_default && !lck_rise && sck_fall
    |=> shift_out_reg[23:1] == $past(shift_out_reg[22:0]))
    else $error("fault word not shifted");
  chk_shift_in: assert property (!hold_default && sck_rise |=> shift_in_reg[0] == $past(sdi_s))
    else $error("serial bit not captured");
  chk_read_clear: assert property (!hold_default && lck_rise && flag_set[1] == 1'b0 |=> !flags_reg[1])
    else $error("flag not cleared on read");
  chk_switch_map: assert property (outputs_live && !hold_default |=> channel_on[4] == $past(cfg_reg[4]))
    else $error("switch bit mismatch");
endmodule

// ### lsr_bank_test.sv
// Self-checking bench for the serial register bank
`timescale 1ns/1ns
module lsr_bank_test;
  logic ref_clk, srst, shift_clock, storage_latch_clock, serial_in;
  logic output_enable_a_n, output_enable_b_n, device_enable_n, clear_n, power_good;
  logic overtemp_detect, apply_ready, serial_out, error_out, error_oe, latch_ready;
  logic [7:0] open_detect, short_detect, sense_enable;
  logic [15:0] channel_on;
  int bad_count = 0;
  int check_count = 0;
  lsr_bank #(.FIFO_DEPTH(16)) uut (.ref_clk(ref_clk), .srst(srst),
    .shift_clock(shift_clock), .storage_latch_clock(storage_latch_clock),
    .serial_in(serial_in), .output_enable_a_n(output_enable_a_n),
    .output_enable_b_n(output_enable_b_n), .device_enable_n(device_enable_n),
    .clear_n(clear_n), .power_good(power_good), .overtemp_detect(overtemp_detect),
    .open_detect(open_detect), .short_detect(short_detect), .apply_ready(apply_ready),
    .channel_on(channel_on), .sense_enable(sense_enable), .serial_out(serial_out),
    .error_out(error_out), .error_oe(error_oe), .latch_ready(latch_ready));
  lsr_host host (.ref_clk(ref_clk), .shift_clock(shift_clock),
    .storage_latch_clock(storage_latch_clock), .serial_in(serial_in),
    .serial_out(serial_out));
  // ==========================================================
  // Helpers
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [5:0] crc6(input logic [23:0] d);
    logic [29:0] r;
    r = {d, 6'h00};
    for (int i = 29; i >= 6; i--) begin
      if (r[i]) r[i -: 7] = r[i -: 7] ^ 7'h43;
    end
    return r[5:0];
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end
  // ==========================================================
  // Tests
  initial begin
    logic [23:0] r;
    srst = 1'b1;
    {output_enable_a_n, output_enable_b_n, device_enable_n, overtemp_detect} = 4'h0;
    {clear_n, power_good, apply_ready} = 3'h7;
    open_detect = 8'h00;
    short_detect = 8'h00;
    cyc(16);
    srst <= 1'b0;
    cyc(4);
    check({8'h00, channel_on}, 24'h000000);
    host.xfer(24'h00a5c3, r);
    check(r, 24'h000000);
    check({8'h00, channel_on}, 24'h00a5c3);
    output_enable_a_n <= 1'b1;
    cyc(6);
    check({8'h00, channel_on}, 24'h000000);
    output_enable_a_n <= 1'b0;
    output_enable_b_n <= 1'b1;
    cyc(6);
    check({8'h00, channel_on}, 24'h000000);
    output_enable_b_n <= 1'b0;
    cyc(6);
    check({8'h00, channel_on}, 24'h00a5c3);
    host.xfer(24'hd70f68, r);
    check({8'h00, channel_on}, 24'h000f68);
    check({16'h0000, sense_enable}, 24'h000000);
    check({23'h0, error_oe}, 24'h000001);
    check({23'h0, error_out}, 24'h000000);
    host.xfer(24'h010001, r);
    check(r, {18'h0, crc6(24'h00a5c3)});
    check({8'h00, channel_on}, 24'h000001);
    check({16'h0000, sense_enable}, 24'h000001);
    open_detect <= 8'h01;
    short_detect <= 8'h01;
    cyc(10);
    open_detect <= 8'h00;
    short_detect <= 8'h00;
    overtemp_detect <= 1'b1;
    cyc(10);
    overtemp_detect <= 1'b0;
    host.xfer(24'h010001, r);
    check(r, 24'h000059);
    host.xfer(24'h010001, r);
    check(r, 24'h0003c0 | crc6(24'h010001));
    check({23'h0, error_oe}, 24'h000000);
    host.xfer(24'h010001, r);
    check(r, {18'h0, crc6(24'h010001)});
    for (int k = 0; k < 3; k++) begin
      host.xfer(24'h00a5c3, r);
      device_enable_n <= (k == 0);
      power_good <= (k != 1);
      clear_n <= (k != 2);
      cyc(8);
      {device_enable_n, power_good, clear_n} <= 3'h3;
      cyc(8);
      check({8'h00, channel_on}, 24'h000000);
    end
    apply_ready <= 1'b0;
    for (int k = 1; k <= 17; k++) host.xfer(24'(k), r);
    check({23'h0, latch_ready}, 24'h000000);
    apply_ready <= 1'b1;
    cyc(40);
    check({8'h00, channel_on}, 24'h000010);
    check({23'h0, latch_ready}, 24'h000001);
    end_of_test();
  end
endmodule

// ### lsr_host.sv
// Host model driving the serial shift and latch pins
`timescale 1ns/1ns
module lsr_host (
  input wire logic ref_clk,
  output logic shift_clock,
  output logic storage_latch_clock,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    shift_clock = 1'b0;
    storage_latch_clock = 1'b0;
    serial_in = 1'b0;
  end
  // Shifts one word in at a 125 ns shift clock, returns the word loaded by the previous latch
  // Data changes with the falling edge, so it stands a half period on each side of the rise
  task automatic xfer(input logic [23:0] wr, output logic [23:0] rd);
    for (int i = 23; i >= 0; i--) begin
      serial_in <= wr[i];
      #63;
      rd[i] = serial_out;
      shift_clock <= 1'b1;
      #62;
      shift_clock <= 1'b0;
    end
    serial_in <= ~wr[0];
    #63;
    storage_latch_clock <= 1'b1;
    #62;
    storage_latch_clock <= 1'b0;
    #63;
    @(posedge ref_clk);
  endtask
endmodule

// ### lsr_pkg.sv
// Constants for the LED driver serial register bank
// Behaviour
// - Channel outputs follow storage only while both active-low enables are low.
// - Power rising past threshold loads defaults; below falling threshold operation stops.
// - Powered with device enable high: standby, all registers held at default.
// - Configuration bits 23..16 are pair selects, pair 14/15 at bit 23.
// - Pair select one with odd bit clear makes odd channel the sense input; zero, plain output.
// - Configuration bits 15..0 each switch the channel of the same index.
// - Configuration register at offset zero, write-only, resets to zero.
// - Fault register at offset one: pair flags 23..8, overtemp 7, error 6, check 5..0.
// - Fault flags clear on read if condition gone; check field read-only; reset zero.
// - Host shifts 24 bits on rising shift clock; latch edge stores them.
// - Latch edge loads fault word to chain; falling shift clock shifts out.
// - Pair select with odd bit set: plain output, command error, error pin low.
// - Check remainder: 24 bits times x^6 divided modulo two by 0x43.
package lsr_pkg;
  localparam int CFG_W = 24;
  localparam int NUM_CH = 16;
  localparam int NUM_PAIRS = 8;
  localparam int CRC_W = 6;
  localparam int FLAG_W = 18;
  localparam logic [1:0] CFG_OFFSET = 2'h0;
  localparam logic [1:0] FAULT_OFFSET = 2'h1;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [17:0] FLAG_RESET = 18'h00000;
  localparam int SEL_LSB = 16;
  localparam int SW_LSB = 0;
  localparam int FLT_PAIR_LSB = 8;
  localparam int FLT_OT_BIT = 7;
  localparam int FLT_CMD_BIT = 6;
  localparam logic [6:0] CRC_POLY = 7'h43;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_W = 25;
endpackage
